/* fdpr_table.sv */
/*
 read-only discovery parameter table, one byte per read request.
 assumes a synchronous requester on clk_i; no write path exists.
*/
// Functional notes
// - relative byte 00h reads the identifier A5h.
// - relative byte 01h reads the following byte count 80h.
// - a F0h padding parameter is only space and readers skip it.
// - discovery data starts at 1120h with E7h.
// - second byte of dword one reads FFh, no 4 KB erase opcode.
// - third byte of dword one reads F3h for the read mode support.
// - dword two is the density 07FFFFFFh, low byte first.
// - quad I/O read reports 44h then opcode EBh.
// - quad output read reports 08h then opcode 6Bh.
// - dual output read reports 08h then opcode 3Bh.
// - dual I/O read reports 80h then opcode BBh.
// - first byte of dword five reads EEh.
// - unused and reserved bytes read FFh.
// - discovery byte n sits at wrapper offset n plus two.
`timescale 1ns/1ps
module fdpr_table
   import fdpr_pkg::*;
(
   input wire logic clk_i,        // 10 MHz clock
   input wire logic sys_rst_i,    // sync reset, active high
   input wire logic rd_i,         // read request strobe
   input wire logic [7:0] addr_i, // wrapper relative offset
   output logic [7:0] data_o,     // byte read
   output logic valid_o           // data_o valid, one cycle
);
   fdpr_state_t s_q, s_d;

   function automatic logic [7:0] disc_byte(input logic [7:0] d);
      logic [7:0] v;
      v = FDPR_RSVD;
      case (d)
         8'h00: v = FDPR_DW1_B0;
         8'h01: v = FDPR_DW1_B1;
         8'h02: v = FDPR_DW1_B2;
         8'h03: v = FDPR_DW1_B3;
         8'h04: v = FDPR_DENSITY[7:0];
         8'h05: v = FDPR_DENSITY[15:8];
         8'h06: v = FDPR_DENSITY[23:16];
         8'h07: v = FDPR_DENSITY[31:24];
         8'h08: v = FDPR_QIO_CYC;
         8'h09: v = FDPR_QIO_OP;
         8'h0A: v = FDPR_QO_CYC;
         8'h0B: v = FDPR_QO_OP;
         8'h0C: v = FDPR_DO_CYC;
         8'h0D: v = FDPR_DO_OP;
         8'h0E: v = FDPR_DIO_CYC;
         8'h0F: v = FDPR_DIO_OP;
         8'h10: v = FDPR_DW5_B0;
         default: v = FDPR_RSVD;
      endcase
      return v;
   endfunction

   function automatic logic [7:0] lookup(input logic [7:0] a);
      logic [7:0] v;
      v = FDPR_RSVD;
      if (a == 8'h00) begin
         v = FDPR_WRAP_ID;
      end else if (a == 8'h01) begin
         v = FDPR_WRAP_LEN;
      end else if (a <= FDPR_LAST) begin
         v = disc_byte(8'(a - FDPR_HDR_BYTES));
      end
      return v;
   endfunction

   always_comb begin
      s_d = s_q;
      s_d.rsp.valid = rd_i;
      if (rd_i) begin
         s_d.rsp.data = lookup(addr_i);
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign data_o = s_q.rsp.data;
   assign valid_o = s_q.rsp.valid;

   a_id_byte: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      rd_i && addr_i == 8'h00 |=> data_o == 8'hA5 && valid_o)
      else $error("id byte wrong");

   a_pad_absent: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      rd_i && addr_i == 8'h00 |=> data_o != FDPR_PAD_ID)
      else $error("id byte reads as padding");

   a_len_byte: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      rd_i && addr_i == 8'h01 |=> data_o == 8'h80)
      else $error("length byte wrong");

   a_first_disc: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      rd_i && addr_i == 8'h02 |=> data_o == 8'hE7)
      else $error("first discovery byte wrong");

   a_no_erase_op: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      rd_i && addr_i == 8'h03 |=> data_o == 8'hFF)
      else $error("erase opcode byte wrong");

   a_read_sup: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      rd_i && addr_i == 8'h04 |=> data_o == 8'hF3)
      else $error("read support byte wrong");

   a_dw1_top: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      rd_i && addr_i == 8'h05 |=> data_o == 8'hFF)
      else $error("dword one top byte wrong");

   a_density_b0: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      rd_i && addr_i == 8'h06 |=> data_o == 8'hFF)
      else $error("density low byte wrong");

   a_density_b1: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      rd_i && addr_i == 8'h07 |=> data_o == 8'hFF)
      else $error("density second byte wrong");

   a_density_b2: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      rd_i && addr_i == 8'h08 |=> data_o == 8'hFF)
      else $error("density third byte wrong");

   a_density_top: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      rd_i && addr_i == 8'h09 |=> data_o == 8'h07)
      else $error("density top byte wrong");

   a_quad_io_cyc: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      rd_i && addr_i == 8'h0A |=> data_o == 8'h44)
      else $error("quad io cycles wrong");

   a_quad_io_op: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      rd_i && addr_i == 8'h0B |=> data_o == 8'hEB)
      else $error("quad io opcode wrong");

   a_quad_io: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      rd_i && addr_i == 8'h0A ##1 rd_i && addr_i == 8'h0B
      |=> $past(data_o) == 8'h44 && data_o == 8'hEB)
      else $error("quad io pair wrong");

   a_quad_out: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      rd_i && addr_i == 8'h0D |=> data_o == 8'h6B)
      else $error("quad out opcode wrong");

   a_shift_two: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      rd_i && addr_i == 8'h0C |=> data_o == 8'h08)
      else $error("header offset wrong");

   a_dual_out_cyc: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      rd_i && addr_i == 8'h0E |=> data_o == 8'h08)
      else $error("dual out cycles wrong");

   a_dual_out: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      rd_i && addr_i == 8'h0F |=> data_o == 8'h3B)
      else $error("dual out opcode wrong");

   a_dual_io: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      rd_i && addr_i == 8'h10 |=> data_o == 8'h80)
      else $error("dual io cycles wrong");

   a_dual_io_op: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      rd_i && addr_i == 8'h11 |=> data_o == 8'hBB)
      else $error("dual io opcode wrong");

   a_dw5_byte: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      rd_i && addr_i == 8'h12 |=> data_o == 8'hEE)
      else $error("dword five byte wrong");

   a_reserved: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      rd_i && addr_i >= 8'h13 |=> data_o == 8'hFF)
      else $error("reserved byte not FF");

   a_stable: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      !rd_i |=> !valid_o && $stable(data_o))
      else $error("data changed without read");

   a_valid_pulse: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      rd_i |=> valid_o)
      else $error("read not answered");

   a_reset_clear: assert property (
      @(posedge clk_i)
      sys_rst_i |=> data_o == 8'h00 && !valid_o)
      else $error("reset did not clear answer");
endmodule

/* fdpr_pkg.sv */
/*
 discovery parameter table constants: wrapper id and length, discovery
 byte values, read cycle/opcode fields, reserved filler.
 assumes nothing of its surroundings; shared by the table module.
*/
package fdpr_pkg;
   localparam logic [7:0] FDPR_WRAP_ID = 8'hA5;
   localparam logic [7:0] FDPR_WRAP_LEN = 8'h80;
   localparam logic [7:0] FDPR_PAD_ID = 8'hF0;
   localparam logic [7:0] FDPR_HDR_BYTES = 8'h02;
   localparam logic [15:0] FDPR_DISC_BASE = 16'h1120;
   localparam logic [7:0] FDPR_RSVD = 8'hFF;
   // first dword
   localparam logic [7:0] FDPR_DW1_B0 = 8'hE7;
   localparam logic [7:0] FDPR_DW1_B1 = 8'hFF;
   localparam logic [7:0] FDPR_DW1_B2 = 8'hF3;
   localparam logic [7:0] FDPR_DW1_B3 = 8'hFF;
   // density, zero based, little endian
   localparam logic [31:0] FDPR_DENSITY = 32'h07FFFFFF;
   // read cycle bytes and opcodes
   localparam logic [7:0] FDPR_QIO_CYC = 8'h44;
   localparam logic [7:0] FDPR_QIO_OP = 8'hEB;
   localparam logic [7:0] FDPR_QO_CYC = 8'h08;
   localparam logic [7:0] FDPR_QO_OP = 8'h6B;
   localparam logic [7:0] FDPR_DO_CYC = 8'h08;
   localparam logic [7:0] FDPR_DO_OP = 8'h3B;
   localparam logic [7:0] FDPR_DIO_CYC = 8'h80;
   localparam logic [7:0] FDPR_DIO_OP = 8'hBB;
   localparam logic [7:0] FDPR_DW5_B0 = 8'hEE;
   // last relative offset covered (id byte + length count)
   localparam logic [7:0] FDPR_LAST = 8'h81;

   typedef struct packed {
      logic [7:0] data;
      logic valid;
   } fdpr_rsp_t;

   typedef struct packed {
      fdpr_rsp_t rsp;
   } fdpr_state_t;
endpackage

/* fdpr_host.sv */
/*
 host side reader of the discovery parameter: finds next parameter start
 and flags padding. assumes one answer per read, one cycle later.
*/
`timescale 1ns/1ps
module fdpr_host
   import fdpr_pkg::*;
(
   input wire logic clk_i,        // clock
   input wire logic rd_i,         // read issued
   input wire logic [7:0] addr_i, // offset read
   input wire logic valid_i,      // answer strobe
   input wire logic [7:0] data_i, // answer byte
   output logic [7:0] next_o,     // next parameter start
   output logic skip_o            // padding seen
);
   logic [7:0] a_q;
   always_ff @(posedge clk_i) begin
      if (rd_i) a_q <= addr_i;
      if (valid_i && a_q == 8'h01) next_o <= a_q + data_i + 8'h01;
      if (valid_i && a_q == 8'h00) skip_o <= (data_i == FDPR_PAD_ID);
   end
endmodule

/* tb_top.sv */
/*
 table-driven bench for the parameter table.
 assumes a one-cycle answer and a sync reset.
*/
`timescale 1ns/1ps
module tb_top
   import fdpr_pkg::*;
;
   logic clk_i = 0, sys_rst_i = 1, rd_i = 0, valid_o, skip_o;
   logic [7:0] addr_i = 8'h00, data_o, next_o;
   int errors = 0, samples_checked = 0, cyc = 0;
   logic [15:0] rows [0:21] = '{16'h00A5, 16'h0180, 16'h02E7, 16'h03FF,
      16'h04F3, 16'h05FF, 16'h06FF, 16'h07FF, 16'h08FF, 16'h0907,
      16'h0A44, 16'h0BEB, 16'h0C08, 16'h0D6B, 16'h0E08, 16'h0F3B,
      16'h1080, 16'h11BB, 16'h12EE, 16'h13FF, 16'h14FF, 16'h81FF};
   always #50 clk_i = ~clk_i;
   fdpr_table dut(.clk_i(clk_i), .sys_rst_i(sys_rst_i), .rd_i(rd_i),
      .addr_i(addr_i), .data_o(data_o), .valid_o(valid_o));
   fdpr_host host(.clk_i(clk_i), .rd_i(rd_i), .addr_i(addr_i),
      .valid_i(valid_o), .data_i(data_o), .next_o(next_o), .skip_o(skip_o));
   task chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task summarize;
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task rd(input logic [7:0] a);
      rd_i = 1;
      addr_i = a;
      @(negedge clk_i);
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 400) begin
         errors++;
         summarize();
      end
   end
   initial begin
      repeat (12) @(negedge clk_i);
      sys_rst_i = 0;
      foreach (rows[i]) begin
         rd(rows[i][15:8]);
         rd_i = 0;
         chk(data_o, rows[i][7:0]);
         chk({7'h00, valid_o}, 8'h01);
         @(negedge clk_i);
         chk({7'h00, valid_o}, 8'h00);
         chk(data_o, rows[i][7:0]);
      end
      // back to back reads
      rd(8'h09);
      chk(data_o, 8'h07);
      rd(8'h0A);
      chk(data_o, 8'h44);
      rd(8'h0B);
      chk(data_o, 8'hEB);
      rd(8'h0D);
      chk(data_o, 8'h6B);
      rd(8'h0F);
      chk(data_o, 8'h3B);
      rd(8'h11);
      chk(data_o, 8'hBB);
      rd(8'h00);
      rd(8'h01);
      rd_i = 0;
      @(negedge clk_i);
      chk(next_o, 8'h82);
      chk({7'h00, skip_o}, 8'h00);
      // reset in mid-run with a request pending
      sys_rst_i = 1;
      rd(8'h00);
      @(negedge clk_i);
      chk(data_o, 8'h00);
      chk({7'h00, valid_o}, 8'h00);
      // first read right after release
      sys_rst_i = 0;
      rd(8'h02);
      rd_i = 0;
      chk(data_o, 8'hE7);
      chk({7'h00, valid_o}, 8'h01);
      summarize();
   end
endmodule
